// file: sfc_params.svh
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
// Opcode sent while probing; a device answers with a non-blank byte
`define SFC_PROBE_OPCODE 8'h9f
// Opcode sent to switch to four lanes; on the single lane unless already in quad
`define SFC_QUAD_EN_OPCODE 8'h38
`define SFC_BLANK_LO 8'h00
`define SFC_BLANK_HI 8'hff
`define SFC_LAST_BIT_SINGLE 4'h7
`define SFC_LAST_BIT_QUAD 4'h1
`define SFC_OE_N_SINGLE 4'he
`define SFC_OE_N_ALL_OUT 4'h0
`define SFC_OE_N_ALL_IN 4'hf
`endif

// file: sfc_pkg.sv
`default_nettype none
package sfc_pkg;
	typedef enum logic [1:0] {
		SFC_INIT,
		SFC_DETACHED,
		SFC_BASIC,
		SFC_FULL
	} sfc_state_t;

	typedef enum logic [2:0] {
		go_full_speed_cmd,
		detach_cmd,
		attach_cmd,
		raw_deselect_cmd,
		raw_transmit_cmd,
		raw_receive_cmd,
		bitmap_cache_flush_cmd
	} sfc_cmd_op_t;

	typedef struct packed {
		sfc_cmd_op_t op;
		logic [7:0] data;
	} sfc_cmd_t;

	typedef enum logic [2:0] {
		LK_PROBE,
		LK_TX,
		LK_RX,
		LK_DESEL,
		LK_QUAD,
		LK_OFF,
		LK_PARK
	} sfc_link_op_t;

	typedef struct packed {
		sfc_link_op_t op;
		logic [7:0] data;
	} sfc_link_req_t;
endpackage : sfc_pkg
`default_nettype wire

// file: sfc_flash_ctrl.sv
// Notes on behaviour
// - Block is master of the flash link
// - Single-lane transfers until the quad switch, flash clock at half the link clock rate
// - State reads initial until detection completes
// - Detection ends detached, or basic if found
// - No device found: clock, select and lane 0 driven low
// - Full-speed command from basic or full switches link, state full
// - Detach accepted anywhere, stops link, detached
// - Detached: raw deselect, transmit, receive
// - Attach from detached re-probes the flash
// - Direct rendering allowed only in full
// - Quad mode uses shared pins as lanes 2-3
`include "sfc_params.svh"
`default_nettype none
module sfc_flash_ctrl (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic link_clk_in,
	input wire sfc_pkg::sfc_cmd_t cmd_in,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	output sfc_pkg::sfc_state_t state_out,
	output logic render_enable_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic cache_flush_out,
	output logic flash_sclk_out,
	output logic flash_cs_n_out,
	input wire logic [1:0] flash_io_in,
	output logic [1:0] flash_io_out,
	output logic [1:0] flash_io_oe_n_out,
	input wire logic shared_pin_data2_in,
	output logic shared_pin_data2_out,
	output logic shared_pin_data2_oe_n_out,
	input wire logic shared_pin_data3_in,
	output logic shared_pin_data3_out,
	output logic shared_pin_data3_oe_n_out
);
	sfc_pkg::sfc_state_t state_q;
	sfc_pkg::sfc_link_req_t lreq_q, iss;
	logic booted_q, ready_q, req_tgl_q, iss_v, acc, done_ev, found;
	logic dn_s1_q, dn_s2_q, dn_seen_q, render_q, flush_q, rx_valid_q;
	logic [7:0] rx_data_q;
	// Link domain
	logic rq_s1_q, rq_s2_q, rq_seen_q, rq_edge, active_q, ph_q, rxm_q, quad_q, park_q;
	logic cs_n_q, sclk_q, dn_tgl_q, byte_end;
	logic [3:0] cnt_q, last_bit, io_o_q, io_oe_n_q, io_s1_q, io_s2_q;
	logic [7:0] sh_q, sh_d, res_q;
	sfc_pkg::sfc_link_op_t lop_q;

	assign done_ev = dn_s2_q ^ dn_seen_q;
	assign acc = cmd_valid_in && ready_q;
	// Result is stable here: the link is idle until the next request
	assign found = (res_q != `SFC_BLANK_LO) && (res_q != `SFC_BLANK_HI);

	always_comb
	begin
		iss_v = 1'b0;
		iss = lreq_q;
		if (!booted_q)
		begin
			iss_v = 1'b1;
			iss.op = sfc_pkg::LK_PROBE;
		end
		else if (done_ev)
		begin
			if (lreq_q.op == sfc_pkg::LK_PROBE && !found)
			begin
				iss_v = 1'b1;
				iss.op = sfc_pkg::LK_PARK;
			end
		end
		else if (acc)
		begin
			iss.data = cmd_in.data;
			case (cmd_in.op)
				sfc_pkg::detach_cmd:
				begin
					iss_v = 1'b1;
					iss.op = sfc_pkg::LK_OFF;
				end
				sfc_pkg::attach_cmd:
				begin
					iss_v = (state_q == sfc_pkg::SFC_DETACHED);
					iss.op = sfc_pkg::LK_PROBE;
				end
				sfc_pkg::go_full_speed_cmd:
				begin
					iss_v = (state_q == sfc_pkg::SFC_BASIC) || (state_q == sfc_pkg::SFC_FULL);
					iss.op = sfc_pkg::LK_QUAD;
				end
				sfc_pkg::raw_deselect_cmd:
				begin
					iss_v = (state_q == sfc_pkg::SFC_DETACHED);
					iss.op = sfc_pkg::LK_DESEL;
				end
				sfc_pkg::raw_transmit_cmd:
				begin
					iss_v = (state_q == sfc_pkg::SFC_DETACHED);
					iss.op = sfc_pkg::LK_TX;
				end
				sfc_pkg::raw_receive_cmd:
				begin
					iss_v = (state_q == sfc_pkg::SFC_DETACHED);
					iss.op = sfc_pkg::LK_RX;
				end
				default:
				begin
					iss_v = 1'b0;
				end
			endcase
		end
	end

	// Request word held still until the link toggles back
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			lreq_q <= '{op: sfc_pkg::LK_OFF, data: 8'h00};
			req_tgl_q <= 1'b0;
			booted_q <= 1'b0;
			ready_q <= 1'b0;
			dn_s1_q <= 1'b0;
			dn_s2_q <= 1'b0;
			dn_seen_q <= 1'b0;
		end
		else
		begin
			booted_q <= 1'b1;
			dn_s1_q <= dn_tgl_q;
			dn_s2_q <= dn_s1_q;
			if (done_ev)
				dn_seen_q <= dn_s2_q;
			if (iss_v)
			begin
				lreq_q <= iss;
				req_tgl_q <= ~req_tgl_q;
				ready_q <= 1'b0;
			end
			else if (done_ev)
				ready_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			state_q <= sfc_pkg::SFC_INIT;
		else if (done_ev && lreq_q.op == sfc_pkg::LK_PROBE)
			state_q <= found ? sfc_pkg::SFC_BASIC : sfc_pkg::SFC_DETACHED;
		else if (done_ev && lreq_q.op == sfc_pkg::LK_QUAD)
			state_q <= sfc_pkg::SFC_FULL;
		else if (acc && cmd_in.op == sfc_pkg::detach_cmd)
			state_q <= sfc_pkg::SFC_DETACHED;
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			render_q <= 1'b0;
			flush_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
		end
		else
		begin
			render_q <= (state_q == sfc_pkg::SFC_FULL);
			flush_q <= acc && cmd_in.op == sfc_pkg::bitmap_cache_flush_cmd;
			rx_valid_q <= done_ev && lreq_q.op == sfc_pkg::LK_RX;
			if (done_ev && lreq_q.op == sfc_pkg::LK_RX)
				rx_data_q <= res_q;
		end
	end

	assign state_out = state_q;
	assign cmd_ready_out = ready_q;
	assign render_enable_out = render_q;
	assign cache_flush_out = flush_q;
	assign rx_valid_out = rx_valid_q;
	assign rx_data_out = rx_data_q;

	// Link side
	always_ff @(posedge link_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			rq_s1_q <= 1'b0;
			rq_s2_q <= 1'b0;
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
		end
		else
		begin
			rq_s1_q <= req_tgl_q;
			rq_s2_q <= rq_s1_q;
			io_s1_q <= {shared_pin_data3_in, shared_pin_data2_in, flash_io_in};
			io_s2_q <= io_s1_q;
		end
	end

	assign rq_edge = rq_s2_q ^ rq_seen_q;
	// two nibbles per byte in quad
	assign last_bit = quad_q ? `SFC_LAST_BIT_QUAD : `SFC_LAST_BIT_SINGLE;
	// Receive runs one extra sample to absorb synchroniser delay
	assign byte_end = (cnt_q == last_bit + {3'h0, rxm_q});

	always_comb
	begin
		if (quad_q)
			sh_d = {sh_q[3:0], rxm_q ? io_s2_q : 4'h0};
		else
			sh_d = {sh_q[6:0], rxm_q & io_s2_q[1]};
	end

	always_ff @(posedge link_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			rq_seen_q <= 1'b0;
			dn_tgl_q <= 1'b0;
			active_q <= 1'b0;
			ph_q <= 1'b0;
			rxm_q <= 1'b0;
			quad_q <= 1'b0;
			park_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			res_q <= 8'h00;
			lop_q <= sfc_pkg::LK_OFF;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			io_o_q <= 4'h0;
			io_oe_n_q <= `SFC_OE_N_SINGLE;
		end
		else if (!active_q && rq_edge)
		begin
			rq_seen_q <= rq_s2_q;
			lop_q <= lreq_q.op;
			sclk_q <= 1'b0;
			io_o_q <= 4'h0;
			case (lreq_q.op)
				sfc_pkg::LK_DESEL:
				begin
					cs_n_q <= 1'b1;
					dn_tgl_q <= ~dn_tgl_q;
				end
				sfc_pkg::LK_OFF:
				begin
					cs_n_q <= 1'b1;
					quad_q <= 1'b0;
					park_q <= 1'b0;
					io_oe_n_q <= `SFC_OE_N_SINGLE;
					dn_tgl_q <= ~dn_tgl_q;
				end
				sfc_pkg::LK_PARK:
				begin
					park_q <= 1'b1;
					cs_n_q <= 1'b0;
					quad_q <= 1'b0;
					io_oe_n_q <= `SFC_OE_N_SINGLE;
					dn_tgl_q <= ~dn_tgl_q;
				end
				default:
				begin
					park_q <= 1'b0;
					cs_n_q <= 1'b0;
					active_q <= 1'b1;
					ph_q <= 1'b0;
					cnt_q <= 4'h0;
					rxm_q <= (lreq_q.op == sfc_pkg::LK_RX);
					if (lreq_q.op == sfc_pkg::LK_PROBE)
						sh_q <= `SFC_PROBE_OPCODE;
					else if (lreq_q.op == sfc_pkg::LK_QUAD)
						sh_q <= `SFC_QUAD_EN_OPCODE;
					else
						sh_q <= lreq_q.data;
				end
			endcase
		end
		else if (active_q)
		begin
			ph_q <= ~ph_q;
			if (!ph_q)
			begin
				sclk_q <= 1'b0;
				if (quad_q)
				begin
					io_o_q <= sh_q[7:4];
					io_oe_n_q <= rxm_q ? `SFC_OE_N_ALL_IN : `SFC_OE_N_ALL_OUT;
				end
				else
				begin
					io_o_q <= {3'h0, sh_q[7]};
					io_oe_n_q <= `SFC_OE_N_SINGLE;
				end
			end
			else
			begin
				sclk_q <= !(rxm_q && byte_end);
				sh_q <= sh_d;
				cnt_q <= cnt_q + 4'h1;
				if (byte_end && lop_q == sfc_pkg::LK_PROBE && !rxm_q)
				begin
					rxm_q <= 1'b1;
					cnt_q <= 4'h0;
				end
				else if (byte_end)
				begin
					active_q <= 1'b0;
					res_q <= sh_d;
					dn_tgl_q <= ~dn_tgl_q;
					if (lop_q == sfc_pkg::LK_PROBE || lop_q == sfc_pkg::LK_QUAD)
						cs_n_q <= 1'b1;
					if (lop_q == sfc_pkg::LK_QUAD)
						quad_q <= 1'b1;
				end
			end
		end
	end

	assign flash_sclk_out = sclk_q;
	assign flash_cs_n_out = cs_n_q;
	assign flash_io_out = io_o_q[1:0];
	assign flash_io_oe_n_out = io_oe_n_q[1:0];
	assign shared_pin_data2_out = io_o_q[2];
	assign shared_pin_data2_oe_n_out = io_oe_n_q[2];
	assign shared_pin_data3_out = io_o_q[3];
	assign shared_pin_data3_oe_n_out = io_oe_n_q[3];

	a_init_holds: assert property (@(posedge mclk_in) disable iff (reset_in)
		state_q == sfc_pkg::SFC_INIT && !done_ev |=> state_q == sfc_pkg::SFC_INIT)
		else $error("state left initial without a detection result");
	a_probe_result: assert property (@(posedge mclk_in) disable iff (reset_in)
		done_ev && lreq_q.op == sfc_pkg::LK_PROBE |=> state_q == ($past(found) ? sfc_pkg::SFC_BASIC
		: sfc_pkg::SFC_DETACHED))
		else $error("detection outcome not reflected in state");
	a_fast_full: assert property (@(posedge mclk_in) disable iff (reset_in)
		done_ev && lreq_q.op == sfc_pkg::LK_QUAD |=> state_q == sfc_pkg::SFC_FULL)
		else $error("quad switch did not reach full");
	a_detach_any: assert property (@(posedge mclk_in) disable iff (reset_in)
		acc && cmd_in.op == sfc_pkg::detach_cmd |=> state_q == sfc_pkg::SFC_DETACHED
		&& lreq_q.op == sfc_pkg::LK_OFF && !ready_q)
		else $error("detach not honoured");
	a_raw_detached: assert property (@(posedge mclk_in) disable iff (reset_in)
		$changed(req_tgl_q) && lreq_q.op inside {sfc_pkg::LK_TX, sfc_pkg::LK_RX, sfc_pkg::LK_DESEL}
		|-> state_q == sfc_pkg::SFC_DETACHED)
		else $error("raw transfer outside detached");
	a_attach_probe: assert property (@(posedge mclk_in) disable iff (reset_in)
		acc && cmd_in.op == sfc_pkg::attach_cmd && state_q == sfc_pkg::SFC_DETACHED
		|=> lreq_q.op == sfc_pkg::LK_PROBE && $changed(req_tgl_q))
		else $error("attach did not start a probe");
	a_render_full: assert property (@(posedge mclk_in) disable iff (reset_in)
		##1 render_enable_out == ($past(state_q) == sfc_pkg::SFC_FULL))
		else $error("render gate disagrees with state");
	a_park_low: assert property (@(posedge link_clk_in) disable iff (reset_in)
		park_q && !active_q |-> !flash_sclk_out && !flash_cs_n_out && flash_io_out[0] == 1'b0
		&& !flash_io_oe_n_out[0])
		else $error("parked link not driven low");
	a_quad_lanes: assert property (@(posedge link_clk_in) disable iff (reset_in)
		active_q && quad_q && !rxm_q && ph_q |-> !shared_pin_data2_oe_n_out && !shared_pin_data3_oe_n_out)
		else $error("shared pins not driven in quad transmit");
endmodule : sfc_flash_ctrl
`default_nettype wire

// file: sfc_flash_model.sv
`default_nettype none
module sfc_flash_model #(
	// Reply byte value is arbitrary, only non-blank matters
	parameter logic [7:0] REPLY = 8'h5a
) (
	input wire logic present_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	output logic miso_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int rise_cnt;

	always @(posedge sclk_in or posedge cs_n_in)
	begin
		if (cs_n_in)
			rise_cnt <= 0;
		else
			rise_cnt <= rise_cnt + 1;
	end

	// Slave answers after one byte from master
	// Pull-up on lane1: absent or deselected reads ff
	always @(negedge sclk_in or posedge cs_n_in)
	begin
		if (cs_n_in || !present_in || rise_cnt < 8)
			miso_out <= 1'b1;
		else
			miso_out <= REPLY[7 - ((rise_cnt - 8) % 8)];
	end

	initial miso_out = 1'b1;
endmodule : sfc_flash_model
`default_nettype wire

// file: testbench.sv
`include "sfc_params.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REPLY = 8'h5a;
	logic mclk = 0;
	logic lclk = 0;
	logic rst = 1;
	logic valid = 0;
	logic present = 0;
	sfc_pkg::sfc_cmd_t cmd = '0;
	sfc_pkg::sfc_state_t state;
	logic ready, render, rxv, flush, sclk, cs_n, miso, d2o, d2e, d3o, d3e;
	logic [7:0] rxd;
	logic [1:0] io_o, io_e;
	int failures = 0;
	int samples_checked = 0;
	int rx_cnt = 0;
	int fl_cnt = 0;
	logic [7:0] cap1 = '0;
	logic [7:0] cap4 = '0;

	always #2 mclk = ~mclk;
	// Odd offset keeps link edges off the system edges
	always
	begin
		#7;
		forever #80 lclk = ~lclk;
	end

	sfc_flash_ctrl uut (.mclk_in(mclk), .reset_in(rst), .link_clk_in(lclk), .cmd_in(cmd),
		.cmd_valid_in(valid), .cmd_ready_out(ready), .state_out(state), .render_enable_out(render),
		.rx_data_out(rxd), .rx_valid_out(rxv), .cache_flush_out(flush), .flash_sclk_out(sclk),
		.flash_cs_n_out(cs_n), .flash_io_in({io_e[1] ? miso : io_o[1], io_e[0] ? 1'b1 : io_o[0]}),
		.flash_io_out(io_o), .flash_io_oe_n_out(io_e), .shared_pin_data2_in(d2e ? 1'b1 : d2o),
		.shared_pin_data2_out(d2o), .shared_pin_data2_oe_n_out(d2e), .shared_pin_data3_in(d3e ? 1'b1 : d3o),
		.shared_pin_data3_out(d3o), .shared_pin_data3_oe_n_out(d3e));
	sfc_flash_model #(.REPLY(REPLY)) u_flash (.present_in(present), .sclk_in(sclk), .cs_n_in(cs_n),
		.miso_out(miso));

	// Lane values as the flash sees them at each rising flash clock (sclk)
	always @(posedge sclk)
	begin
		cap1 <= {cap1[6:0], io_o[0]};
		cap4 <= {cap4[3:0], d3o, d2o, io_o};
	end

	// Pulses stand one cycle; count them away from the launching edge
	always @(negedge mclk)
	begin
		if (rxv === 1'b1)
			rx_cnt++;
		if (flush === 1'b1)
			fl_cnt++;
	end

	task finish_test;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task chk_state(input sfc_pkg::sfc_state_t exp);
		check(8'(state), 8'(exp));
	endtask : chk_state

	task wait_ready;
		for (int i = 0; i < 5000 && ready !== 1'b1; i++)
			@(negedge mclk);
		if (ready !== 1'b1)
		begin
			failures++;
			$display("[ERR] %0t command port stuck busy", $time);
			finish_test();
		end
	endtask : wait_ready

	task send(input sfc_pkg::sfc_cmd_op_t op, input logic [7:0] d);
		wait_ready();
		cmd.op = op;
		cmd.data = d;
		valid = 1'b1;
		@(negedge mclk);
		valid = 1'b0;
		@(negedge mclk);
		wait_ready();
	endtask : send

	// Reset must span two link edges as well
	task do_reset(input logic p);
		present = p;
		rst = 1'b1;
		repeat (2) @(posedge lclk);
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		chk_state(sfc_pkg::SFC_INIT);
		check(8'(ready), 8'h00);
	endtask : do_reset

	task t_absent;
		do_reset(1'b0);
		wait_ready();
		chk_state(sfc_pkg::SFC_DETACHED);
		check(8'({sclk, cs_n, io_o[0], io_e[0]}), 8'h00);
		check(8'(render), 8'h00);
		send(sfc_pkg::go_full_speed_cmd, 8'h00);
		chk_state(sfc_pkg::SFC_DETACHED);
	endtask : t_absent

	task t_found;
		do_reset(1'b1);
		wait_ready();
		chk_state(sfc_pkg::SFC_BASIC);
		check(8'(cs_n), 8'h01);
		send(sfc_pkg::raw_transmit_cmd, 8'h9f);
		chk_state(sfc_pkg::SFC_BASIC);
		check(8'(cs_n), 8'h01);
		send(sfc_pkg::attach_cmd, 8'h00);
		chk_state(sfc_pkg::SFC_BASIC);
	endtask : t_found

	task t_raw;
		int n;
		send(sfc_pkg::detach_cmd, 8'h00);
		chk_state(sfc_pkg::SFC_DETACHED);
		send(sfc_pkg::raw_transmit_cmd, 8'h9f);
		check(8'(cs_n), 8'h00);
		check(cap1, 8'h9f);
		n = rx_cnt;
		send(sfc_pkg::raw_receive_cmd, 8'h00);
		repeat (2) @(negedge mclk);
		check(rxd, REPLY);
		check(8'(rx_cnt - n), 8'h01);
		send(sfc_pkg::raw_deselect_cmd, 8'h00);
		check(8'(cs_n), 8'h01);
	endtask : t_raw

	task t_attach;
		send(sfc_pkg::attach_cmd, 8'h00);
		chk_state(sfc_pkg::SFC_BASIC);
	endtask : t_attach

	task t_fast;
		int n;
		check(8'(render), 8'h00);
		send(sfc_pkg::go_full_speed_cmd, 8'h00);
		repeat (2) @(negedge mclk);
		chk_state(sfc_pkg::SFC_FULL);
		check(8'(render), 8'h01);
		// Already in quad: the opcode now goes out on all four lanes
		send(sfc_pkg::go_full_speed_cmd, 8'h00);
		check(cap4, `SFC_QUAD_EN_OPCODE);
		chk_state(sfc_pkg::SFC_FULL);
		n = fl_cnt;
		send(sfc_pkg::bitmap_cache_flush_cmd, 8'h00);
		repeat (2) @(negedge mclk);
		check(8'(fl_cnt - n), 8'h01);
		send(sfc_pkg::detach_cmd, 8'h00);
		repeat (2) @(negedge mclk);
		chk_state(sfc_pkg::SFC_DETACHED);
		check(8'(render), 8'h00);
		check(8'({d2e, d3e}), 8'h03);
	endtask : t_fast

	initial
	begin
		t_absent();
		t_found();
		t_raw();
		t_attach();
		t_fast();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
